// ---- rtl/lpm_sequencer.sv ----
// Power-mode, frame time base and gear sequencer
`timescale 1ns/10ps
`include "lpm_map.svh"
module lpm_sequencer #(
    parameter int SUB_SLOW_CYC  = `SUB_SLOW_NS / `CLK_PERIOD_NS,
    parameter int SUB_FAST_CYC  = `SUB_FAST_NS / `CLK_PERIOD_NS,
    parameter int FRAME_LONG_CYC  = `FRAME_LONG_NS / `CLK_PERIOD_NS,
    parameter int FRAME_SHORT_CYC = `FRAME_SHORT_NS / `CLK_PERIOD_NS,
    parameter int SETTLE_CYC    = (`OSC_SETTLE_NS + `CLK_PERIOD_NS - 1)
                                  / `CLK_PERIOD_NS
) (
    input  wire logic       ref_clk_in,      // 50 MHz system clock
    input  wire logic       arst_n_in,       // Async reset, active low
    input  wire logic [5:0] addr_in,         // Register address
    input  wire logic [3:0] wdata_in,        // Register write data
    input  wire logic       wr_in,           // Write strobe
    input  wire logic       rd_in,           // Read strobe
    output logic      [3:0] rdata_out,       // Read data, next cycle
    input  wire logic       instr_stop_in,   // Stop instruction executed
    input  wire logic       instr_standby_in, // Standby instruction executed
    input  wire logic       watch_select_bit_in, // Stop goes to watch
    input  wire logic       interrupt_enable_flag_in, // CPU enable flag
    input  wire logic       irq_pending_in,  // Any unmasked request set
    input  wire logic       timer_a_mask_in, // Timer A request masked
    input  wire logic       ext_int_zero_n_in, // Interrupt 0 pin
    input  wire logic [3:0] wakeup_n_in,     // Wakeup pins
    output logic      [2:0] mode_out,        // Current mode
    output logic            main_osc_en_out, // Main oscillator enable
    output logic            adc_en_out,      // Converter clock enable
    output logic            cpu_run_out,     // Instruction execution on
    output logic            instr_clk_en_out, // Instruction cycle pulse
    output logic            frame_strobe_out, // Interrupt frame strobe
    output logic            external_interrupt_zero_req_out,    // Interrupt 0 request pulse
    output logic            wakeup_req_out,  // Wakeup request pulse
    output logic            timer_a_req_out  // Timer A overflow pulse
);
    localparam int GEAR_SYNC = `GEAR_SYNC_CYC;

    lpm_pkg::mode_t mode;
    lpm_pkg::mode_t next_mode;
    logic [3:0]  sys_clk_sel;
    logic [3:0]  misc;
    logic        low_speed_on_flag;
    logic        direct_transfer_on_flag;
    logic        gear_enable_flag;
    logic [4:0]  pin_meta;
    logic [4:0]  pin_sync;
    logic [4:0]  pin_prev;
    logic [4:0]  frame_edge;
    logic [15:0] frame_cnt;
    logic [13:0] div_cnt;
    logic [12:0] settle_cnt;
    logic [2:0]  held_req;

    wire in_active   = (mode == lpm_pkg::MODE_ACTIVE);
    wire in_sub      = (mode == lpm_pkg::MODE_SUBACTIVE);
    wire in_watch    = (mode == lpm_pkg::MODE_WATCH);
    wire low_power   = in_sub | in_watch;
    wire instr_any   = instr_stop_in | instr_standby_in;
    wire instr_nop   = ~interrupt_enable_flag_in & irq_pending_in;
    wire instr_go    = instr_any & ~instr_nop;
    wire direct_sel  = direct_transfer_on_flag & ~low_speed_on_flag;
    wire wr_sys      = wr_in & (addr_in == `ADDR_SYS_CLK_SEL);
    wire wr_misc     = wr_in & (addr_in == `ADDR_MISC);
    wire wr_flags    = wr_in & (addr_in == `ADDR_LP_FLAGS);
    wire wr_gear     = wr_in & (addr_in == `ADDR_GEAR_FLAG);
    wire gear_slow   = sys_clk_sel[`BIT_GEAR_RATIO];
    wire sub_slow    = sys_clk_sel[`BIT_SUB_SPEED];
    // Field zero picks the long frame, any other code the short one
    wire frame_long  = (misc[1:0] == 2'b00);
    wire [15:0] frame_last = frame_long ? 16'(FRAME_LONG_CYC - 1)
                                        : 16'(FRAME_SHORT_CYC - 1);
    // A shorter period picked mid-frame must not run the counter round
    wire frame_wrap  = (frame_cnt >= frame_last);
    wire [13:0] div_last = in_sub ? (sub_slow ? 14'(SUB_SLOW_CYC - 1)
                                              : 14'(SUB_FAST_CYC - 1))
                                  : (gear_slow ? 14'(`GEAR_DIV_SLOW - 1)
                                               : 14'(`GEAR_DIV_FAST - 1));
    wire div_run     = in_active | in_sub;
    wire settle_done = (mode == lpm_pkg::MODE_SETTLE) &&
                       (settle_cnt == 13'(SETTLE_CYC - 1));
    wire gear_done   = (mode == lpm_pkg::MODE_GEAR) &&
                       (settle_cnt == 13'(GEAR_SYNC - 1));
    // Frame edges serve subactive and watch; immediate edges every other mode
    wire [4:0] fast_edge = pin_prev & ~pin_sync;
    wire external_interrupt_zero_edge   = low_power ? frame_edge[0] : fast_edge[0];
    wire wu_edge     = low_power ? |frame_edge[4:1] : |fast_edge[4:1];
    wire ta_event    = frame_strobe_out & ~timer_a_mask_in;
    wire watch_wake  = external_interrupt_zero_edge | wu_edge | ta_event;
    wire to_settle   = in_watch & watch_wake & ~low_speed_on_flag;
    wire [3:0] lp_flags_rd = {direct_transfer_on_flag, 2'b00,
                              low_speed_on_flag};
    wire [3:0] rd_mux =
        (addr_in == `ADDR_SYS_CLK_SEL) ? sys_clk_sel :
        (addr_in == `ADDR_MISC)        ? misc :
        (addr_in == `ADDR_LP_FLAGS)    ? lp_flags_rd :
        (addr_in == `ADDR_GEAR_FLAG)   ? {gear_enable_flag, 3'b000} :
        (addr_in == `ADDR_MODE_STATUS) ? {1'b0, mode} : 4'h0;

    frame_edge_sampler u_sampler (
        .ref_clk_in (ref_clk_in),
        .arst_n_in  (arst_n_in),
        .strobe_in  (frame_strobe_out),
        .level_in   (pin_sync),
        .edge_out   (frame_edge)
    );

    always_comb begin
        next_mode = mode;
        case (mode)
            lpm_pkg::MODE_ACTIVE: begin
                if (instr_go && instr_standby_in) begin
                    next_mode = gear_enable_flag ? lpm_pkg::MODE_GEAR
                                                 : lpm_pkg::MODE_STANDBY;
                end else if (instr_go) begin
                    next_mode = watch_select_bit_in ? lpm_pkg::MODE_WATCH
                                                    : lpm_pkg::MODE_STOP;
                end
            end
            lpm_pkg::MODE_STANDBY: begin
                if (irq_pending_in | external_interrupt_zero_edge | wu_edge | ta_event) begin
                    next_mode = lpm_pkg::MODE_ACTIVE;
                end
            end
            lpm_pkg::MODE_STOP: begin
                if (|fast_edge[4:1]) begin
                    next_mode = lpm_pkg::MODE_SETTLE;
                end
            end
            lpm_pkg::MODE_WATCH: begin
                if (watch_wake) begin
                    next_mode = low_speed_on_flag ? lpm_pkg::MODE_SUBACTIVE
                                                  : lpm_pkg::MODE_SETTLE;
                end
            end
            lpm_pkg::MODE_SUBACTIVE: begin
                if (instr_go) begin
                    next_mode = direct_sel ? lpm_pkg::MODE_DIRECT_WAIT
                                           : lpm_pkg::MODE_WATCH;
                end
            end
            lpm_pkg::MODE_DIRECT_WAIT: begin
                // Waiting for the frame edge keeps the switch under one
                // frame plus settling
                if (frame_strobe_out) begin
                    next_mode = lpm_pkg::MODE_SETTLE;
                end
            end
            lpm_pkg::MODE_SETTLE: begin
                if (settle_done) begin
                    next_mode = lpm_pkg::MODE_ACTIVE;
                end
            end
            lpm_pkg::MODE_GEAR: begin
                if (gear_done) begin
                    next_mode = lpm_pkg::MODE_ACTIVE;
                end
            end
            default: begin
                next_mode = lpm_pkg::MODE_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode <= lpm_pkg::MODE_ACTIVE;
        end else begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_meta <= 5'h1f;
            pin_sync <= 5'h1f;
            pin_prev <= 5'h1f;
        end else begin
            pin_meta <= {wakeup_n_in, ext_int_zero_n_in};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Frame base runs on every mode so the sampler keeps its phase
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            frame_cnt        <= 16'h0000;
            frame_strobe_out <= 1'b0;
        end else begin
            frame_cnt        <= frame_wrap ? 16'h0000 : frame_cnt + 16'h0001;
            frame_strobe_out <= frame_wrap;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_cnt          <= 14'h0000;
            instr_clk_en_out <= 1'b0;
        end else if (!div_run || div_cnt >= div_last) begin
            div_cnt          <= 14'h0000;
            instr_clk_en_out <= div_run;
        end else begin
            div_cnt          <= div_cnt + 14'h0001;
            instr_clk_en_out <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            settle_cnt <= 13'h0000;
        end else if (mode != next_mode) begin
            settle_cnt <= 13'h0000;
        end else begin
            settle_cnt <= settle_cnt + 13'h0001;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sys_clk_sel             <= `RST_SYS_CLK_SEL;
            misc                    <= `RST_MISC;
            low_speed_on_flag       <= 1'b0;
            direct_transfer_on_flag <= 1'b0;
            gear_enable_flag        <= 1'b0;
        end else begin
            if (wr_sys) begin
                sys_clk_sel <= wdata_in;
            end
            if (wr_misc) begin
                misc <= wdata_in;
            end
            if (wr_flags) begin
                low_speed_on_flag <= wdata_in[`BIT_LOW_SPEED_ON];
            end
            if (in_active) begin
                direct_transfer_on_flag <= 1'b0;
            end else if (wr_flags && in_sub) begin
                direct_transfer_on_flag <= wdata_in[`BIT_DIRECT_XFER];
            end
            // A write of one in the clearing cycle still sets the flag
            if (wr_gear) begin
                gear_enable_flag <= wdata_in[`BIT_GEAR_ENABLE];
            end else if (gear_done) begin
                gear_enable_flag <= 1'b0;
            end
        end
    end

    // Requests found in watch on the way to active wait out the settling
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            held_req        <= 3'b000;
            external_interrupt_zero_req_out    <= 1'b0;
            wakeup_req_out  <= 1'b0;
            timer_a_req_out <= 1'b0;
        end else if (to_settle) begin
            held_req        <= {ta_event, wu_edge, external_interrupt_zero_edge};
            external_interrupt_zero_req_out    <= 1'b0;
            wakeup_req_out  <= 1'b0;
            timer_a_req_out <= 1'b0;
        end else if (settle_done) begin
            held_req        <= 3'b000;
            external_interrupt_zero_req_out    <= held_req[0];
            wakeup_req_out  <= held_req[1];
            timer_a_req_out <= held_req[2];
        end else begin
            external_interrupt_zero_req_out    <= external_interrupt_zero_edge;
            wakeup_req_out  <= wu_edge;
            timer_a_req_out <= frame_strobe_out &&
                               mode != lpm_pkg::MODE_STOP;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_out <= 4'h0;
        end else begin
            rdata_out <= rd_in ? rd_mux : 4'h0;
        end
    end

    assign mode_out        = mode;
    assign main_osc_en_out = !(low_power || mode == lpm_pkg::MODE_STOP ||
                               mode == lpm_pkg::MODE_DIRECT_WAIT);
    assign adc_en_out      = in_active | (mode == lpm_pkg::MODE_STANDBY);
    assign cpu_run_out     = div_run;

    AST_SUB_CLOCKS: assert property (@(posedge ref_clk_in)
        disable iff (!arst_n_in)
        in_sub |-> !main_osc_en_out && !adc_en_out)
        else $error("main oscillator or converter on in subactive");

    AST_NOP_CANCEL: assert property (@(posedge ref_clk_in)
        disable iff (!arst_n_in)
        in_active && instr_any && !interrupt_enable_flag_in
        && irq_pending_in |=> mode == lpm_pkg::MODE_ACTIVE)
        else $error("stop or standby not cancelled");

    AST_DIRECT_TRANSFER_ON_FLAG_ACTIVE: assert property (@(posedge ref_clk_in)
        disable iff (!arst_n_in)
        in_active ##1 in_active |-> !direct_transfer_on_flag)
        else $error("direct flag set in active mode");

    AST_SUB_TO_WATCH: assert property (@(posedge ref_clk_in)
        disable iff (!arst_n_in)
        in_sub && instr_go && !direct_sel |=> in_watch)
        else $error("subactive exit did not reach watch");

    AST_WATCH_TO_SUB: assert property (@(posedge ref_clk_in)
        disable iff (!arst_n_in)
        in_watch && watch_wake && low_speed_on_flag |=> in_sub)
        else $error("watch wake did not reach subactive");

    AST_GEAR_ENTRY: assert property (@(posedge ref_clk_in)
        disable iff (!arst_n_in)
        in_active && instr_standby_in && !instr_nop && gear_enable_flag
        |=> mode == lpm_pkg::MODE_GEAR)
        else $error("gear conversion not entered");

    AST_GEAR_RETURN: assert property (@(posedge ref_clk_in)
        disable iff (!arst_n_in)
        $rose(mode == lpm_pkg::MODE_GEAR) |->
        ##[31:32] in_active ##0 !gear_enable_flag)
        else $error("gear conversion did not return and clear");

    AST_GEAR_DIV4: assert property (@(posedge ref_clk_in)
        disable iff (!arst_n_in)
        in_active && instr_clk_en_out && !gear_slow && !wr_sys
        |=> !instr_clk_en_out [*3] ##1 (instr_clk_en_out || !in_active))
        else $error("divide by four spacing wrong");

    AST_FRAME_EDGE: assert property (@(posedge ref_clk_in)
        disable iff (!arst_n_in)
        low_power && $past(low_power) && external_interrupt_zero_req_out
        |-> $past(frame_strobe_out, 2))
        else $error("low-power request off the frame strobe");
endmodule

// ---- rtl/lpm_map.svh ----
// Offsets, field positions, reset values and timing for the mode sequencer
// How it works
// - Subactive: main oscillator off, converter off
// - Subactive instruction cycle 244 or 122 us
// - Stop/standby in subactive goes watch or active
// - Frame time base feeds wake and interrupt logic
// - Frame period selectable by miscellaneous register field
// - Low-power requests raised at frame strobe
// - Low-speed 0, direct 1, then stop/standby: active
// - Direct flag settable only subactive, cleared active
// - Direct transition between settling and frame+settling
// - Reset asynchronous, forces reset state at once
// - Stop/standby is no-op if request pending, disabled
// - Inputs sampled once per frame in subactive and watch, high-then-low edge
// - Active instruction clock is system clock over 4 or 32
// - Gear enable plus standby starts gear conversion
// - Gear conversion returns active, clears gear enable
// - Watch wake: active if low-speed 0, else subactive
// - Subactive stop/standby without direct goes to watch
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH

`define ADDR_SYS_CLK_SEL   6'h04
`define ADDR_MISC          6'h05
`define ADDR_LP_FLAGS      6'h20
`define ADDR_GEAR_FLAG     6'h21
`define ADDR_MODE_STATUS   6'h3f

`define BIT_GEAR_RATIO     0
`define BIT_OSC_FREQ       1
`define BIT_SUB_SPEED      2
`define BIT_LOW_SPEED_ON   0
`define BIT_DIRECT_XFER    3
`define BIT_GEAR_ENABLE    3

`define RST_SYS_CLK_SEL    4'h0
`define RST_MISC           4'h0

`define CLK_PERIOD_NS      20
`define SUB_SLOW_NS        244000
`define SUB_FAST_NS        122000
`define FRAME_LONG_NS      1000000
`define FRAME_SHORT_NS     500000
`define OSC_SETTLE_NS      100000
`define GEAR_DIV_FAST      4
`define GEAR_DIV_SLOW      32
`define GEAR_SYNC_CYC      32

`endif

// ---- rtl/lpm_pkg.sv ----
// Types shared by the mode sequencer files
package lpm_pkg;
    typedef enum logic [2:0] {
        MODE_ACTIVE,
        MODE_STANDBY,
        MODE_STOP,
        MODE_WATCH,
        MODE_SUBACTIVE,
        MODE_DIRECT_WAIT,
        MODE_SETTLE,
        MODE_GEAR
    } mode_t;
endpackage

// ---- rtl/frame_edge_sampler.sv ----
// Per-frame falling edge sampler for the interrupt and wakeup inputs
`timescale 1ns/10ps
module frame_edge_sampler (
    input  wire logic       ref_clk_in,   // System clock
    input  wire logic       arst_n_in,    // Async reset, active low
    input  wire logic       strobe_in,    // Frame strobe pulse
    input  wire logic [4:0] level_in,     // Synchronised pin levels
    output logic      [4:0] edge_out      // Falling edge seen, one pulse
);
    logic [4:0] sample;

    genvar i;
    generate
        for (i = 0; i < 5; i = i + 1) begin : g_bit
            always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    sample[i]   <= 1'b1;
                    edge_out[i] <= 1'b0;
                end else begin
                    edge_out[i] <= strobe_in & sample[i] & ~level_in[i];
                    if (strobe_in) begin
                        sample[i] <= level_in[i];
                    end
                end
            end
        end
    endgenerate
endmodule

// ---- verif/pin_partner.sv ----
// External source model for the interrupt 0 and wakeup pins
`timescale 1ns/10ps
module pin_partner #(
    parameter int HOLD_CYC = 192
) (
    input  wire logic       ref_clk_in,  // System clock
    input  wire logic [4:0] fire_in,     // Pulse: pull the selected pins low
    output logic      [4:0] pins_n_out   // Bit 4 interrupt 0, 3:0 wakeup
);
    logic [4:0] level = 5'h1f;
    int         cnt   = 0;

    assign pins_n_out = level;

    // Low level held for several frames so per-frame sampling sees it
    always @(posedge ref_clk_in) begin
        if (fire_in != 5'h00) begin
            level <= ~fire_in;
            cnt   <= HOLD_CYC;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else begin
            level <= 5'h1f;
            cnt   <= 0;
        end
    end
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the mode, frame and gear sequencer
`timescale 1ns/10ps
module testbench;
    localparam int FL = 64;
    localparam int ST = 16;
    logic       ref_clk = 1'b0;
    logic       arst_n = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [3:0] wdata = 4'h0;
    logic       wr = 1'b0, rd = 1'b0, stp = 1'b0, stby = 1'b0;
    logic       wsel = 1'b0, int_en = 1'b1, irqp = 1'b0, tmask = 1'b1;
    logic [4:0] fire = 5'h00, pins_n;
    logic [3:0] rdata;
    logic [2:0] mode;
    logic       osc, adc, run, iclk, fstr, i0r, wur, tar;
    int         i0_cnt = 0, wu_cnt = 0, i0_base, wu_base;
    int         fail_count = 0, comparisons = 0, n;

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (i0r === 1'b1) i0_cnt <= i0_cnt + 1;
        if (wur === 1'b1) wu_cnt <= wu_cnt + 1;
    end

    pin_partner #(.HOLD_CYC(3 * FL)) partner (.ref_clk_in(ref_clk),
        .fire_in(fire), .pins_n_out(pins_n));

    lpm_sequencer #(.SUB_SLOW_CYC(40), .SUB_FAST_CYC(20),
        .FRAME_LONG_CYC(FL), .FRAME_SHORT_CYC(32), .SETTLE_CYC(ST)) dut (
        .ref_clk_in(ref_clk), .arst_n_in(arst_n), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .instr_stop_in(stp), .instr_standby_in(stby),
        .watch_select_bit_in(wsel), .interrupt_enable_flag_in(int_en),
        .irq_pending_in(irqp), .timer_a_mask_in(tmask),
        .ext_int_zero_n_in(pins_n[4]), .wakeup_n_in(pins_n[3:0]),
        .mode_out(mode), .main_osc_en_out(osc), .adc_en_out(adc),
        .cpu_run_out(run), .instr_clk_en_out(iclk),
        .frame_strobe_out(fstr), .external_interrupt_zero_req_out(i0r),
        .wakeup_req_out(wur), .timer_a_req_out(tar));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cm(input lpm_pkg::mode_t m);
        chk({13'h0, mode}, {13'h0, m});
    endtask

    task automatic wreg(input logic [5:0] a, input logic [3:0] d);
        @(posedge ref_clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [5:0] a, input logic [3:0] exp);
        @(posedge ref_clk);
        addr <= a; rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 chk({12'h0, rdata}, {12'h0, exp});
    endtask

    task automatic instr(input logic is_stop);
        @(posedge ref_clk);
        if (is_stop) stp <= 1'b1; else stby <= 1'b1;
        @(posedge ref_clk);
        stp <= 1'b0; stby <= 1'b0;
        #1;
    endtask

    task automatic wait_mode(input lpm_pkg::mode_t m, output int k);
        k = 0;
        while (mode !== m && k < 1000) begin
            @(posedge ref_clk); #1; k++;
        end
    endtask

    // Cycles between two consecutive pulses of the chosen strobe
    task automatic gap(input logic frm, output int k);
        k = 0;
        do begin @(posedge ref_clk); #1; k++; end
        while ((frm ? fstr : iclk) !== 1'b1 && k < 5000);
        k = 0;
        do begin @(posedge ref_clk); #1; k++; end
        while ((frm ? fstr : iclk) !== 1'b1 && k < 5000);
    endtask

    task automatic t_reset();
        cm(lpm_pkg::MODE_ACTIVE);
        chk({13'h0, osc, adc, run}, 16'h0007);
        rreg(6'h04, 4'h0);
        rreg(6'h05, 4'h0);
        wreg(6'h10, 4'hf);
        rreg(6'h10, 4'h0);
        wreg(6'h20, 4'h8);
        rreg(6'h20, 4'h0);
    endtask

    task automatic t_frame();
        gap(1'b1, n);
        chk(16'(n), 16'(FL));
        @(posedge ref_clk); #1 chk({15'h0, tar}, 16'h0001);
        wreg(6'h05, 4'h1);
        gap(1'b1, n);
        chk(16'(n), 16'h0020);
        wreg(6'h05, 4'h0);
    endtask

    task automatic t_gear(input logic [3:0] ratio, input int div);
        int_en <= 1'b0;
        wreg(6'h04, ratio);
        wreg(6'h21, 4'h8);
        instr(1'b0);
        cm(lpm_pkg::MODE_GEAR);
        wait_mode(lpm_pkg::MODE_ACTIVE, n);
        chk(16'(n), 16'h0020);
        rreg(6'h21, 4'h0);
        gap(1'b0, n);
        chk(16'(n), 16'(div));
        @(posedge ref_clk);
        int_en <= 1'b1;
    endtask

    task automatic t_standby();
        instr(1'b0);
        cm(lpm_pkg::MODE_STANDBY);
        @(posedge ref_clk);
        irqp <= 1'b1;
        wait_mode(lpm_pkg::MODE_ACTIVE, n);
        chk({15'h0, n < 8}, 16'h0001);
        @(posedge ref_clk);
        int_en <= 1'b0;
        instr(1'b1);
        cm(lpm_pkg::MODE_ACTIVE);
        @(posedge ref_clk);
        irqp <= 1'b0;
        int_en <= 1'b1;
    endtask

    // Watch entry from active, then interrupt 0 and a wakeup pin together bring subactive
    task automatic to_sub();
        wreg(6'h20, 4'h1);
        wsel <= 1'b1;
        instr(1'b1);
        cm(lpm_pkg::MODE_WATCH);
        chk({13'h0, osc, adc, run}, 16'h0000);
        @(posedge ref_clk);
        i0_base = i0_cnt;
        wu_base = wu_cnt;
        fire <= 5'h11;
        @(posedge ref_clk);
        fire <= 5'h00;
        wait_mode(lpm_pkg::MODE_SUBACTIVE, n);
        cm(lpm_pkg::MODE_SUBACTIVE);
        chk({13'h0, osc, adc, run}, 16'h0001);
        repeat (3 * FL) @(posedge ref_clk);
        chk(16'(wu_cnt - wu_base), 16'h0001);
        chk(16'(i0_cnt - i0_base), 16'h0001);
    endtask

    task automatic t_sub_watch();
        to_sub();
        gap(1'b0, n);
        chk(16'(n), 16'h0014);
        wreg(6'h20, 4'h0);
        instr(1'b1);
        cm(lpm_pkg::MODE_WATCH);
        @(posedge ref_clk);
        i0_base = i0_cnt;
        fire <= 5'h10;
        @(posedge ref_clk);
        fire <= 5'h00;
        wait_mode(lpm_pkg::MODE_ACTIVE, n);
        cm(lpm_pkg::MODE_ACTIVE);
        repeat (4) @(posedge ref_clk);
        #1 chk(16'(i0_cnt - i0_base), 16'h0001);
        repeat (3 * FL) @(posedge ref_clk);
    endtask

    task automatic t_direct();
        wreg(6'h04, 4'h4);
        to_sub();
        gap(1'b0, n);
        chk(16'(n), 16'h0028);
        wreg(6'h20, 4'h8);
        rreg(6'h20, 4'h8);
        instr(1'b0);
        cm(lpm_pkg::MODE_DIRECT_WAIT);
        wait_mode(lpm_pkg::MODE_ACTIVE, n);
        chk({15'h0, n > ST && n < FL + ST + 2}, 16'h0001);
        rreg(6'h20, 4'h0);
        wreg(6'h04, 4'h0);
    endtask

    // Stop entry, then a wakeup pin edge brings active after settling
    task automatic t_stop();
        wsel <= 1'b0;
        instr(1'b1);
        cm(lpm_pkg::MODE_STOP);
        chk({13'h0, osc, adc, run}, 16'h0000);
        @(posedge ref_clk);
        fire <= 5'h02;
        @(posedge ref_clk);
        fire <= 5'h00;
        wait_mode(lpm_pkg::MODE_ACTIVE, n);
        chk({15'h0, n > ST && n < ST + 8}, 16'h0001);
        repeat (3 * FL) @(posedge ref_clk);
        wsel <= 1'b1;
    endtask

    task automatic t_async_reset();
        wreg(6'h05, 4'h3);
        instr(1'b1);
        cm(lpm_pkg::MODE_WATCH);
        #5 arst_n = 1'b0;
        #1 cm(lpm_pkg::MODE_ACTIVE);
        chk({15'h0, osc}, 16'h0001);
        @(posedge ref_clk);
        arst_n <= 1'b1;
        rreg(6'h05, 4'h0);
        cm(lpm_pkg::MODE_ACTIVE);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge ref_clk);
        fail_count++;
        complete_run();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        #1 t_reset();
        t_frame();
        t_gear(4'h1, 32);
        t_gear(4'h0, 4);
        t_standby();
        t_sub_watch();
        t_direct();
        t_stop();
        t_async_reset();
        complete_run();
    end
endmodule
